// ==== smw_defs.svh ====
// register offsets, field positions, reset values for sleep wake-up control
`ifndef SMW_DEFS_SVH
`define SMW_DEFS_SVH
`define SMW_CLKCFG_ADDR     8'ha1
`define SMW_PU0_ADDR        8'hb2
`define SMW_PU1_ADDR        8'hb3
`define SMW_PU2_ADDR        8'hb4
`define SMW_PWRCTL_ADDR     8'hc5
`define SMW_TIRQ_ADDR       8'hd9
`define SMW_WSTAT_ADDR      8'hda
`define SMW_PINSEL_ADDR     8'hdb
`define SMW_PMIE_ADDR       8'hec
`define SMW_PCFG_ADDR       8'hf4
`define SMW_SCR0_ADDR       8'hfb
`define SMW_SCR3_ADDR       8'hfe
`define SMW_ALARM_EN_BIT    1
`define SMW_DC_EN_BIT       0
`define SMW_SLEEP_BIT       4
`define SMW_DISP_EN_BIT     0
`define SMW_RXFLAG_BIT      7
`define SMW_SUPSRC_BIT      6
`define SMW_E0_EDGE_BIT     0
`define SMW_E1_EDGE_BIT     1
`define SMW_E0_LATCH_BIT    2
`define SMW_E1_LATCH_BIT    3
`define SMW_ST_DC_BIT       0
`define SMW_ST_SUP_BIT      1
`define SMW_ST_MID_BIT      2
`define SMW_ST_ALM_BIT      3
`define SMW_PU_RST          8'hff
`define SMW_REG_RST         8'h00
`define SMW_SYNC_RST        8'hf0
`define SMW_IN_DC           0
`define SMW_IN_RAIL         1
`define SMW_IN_MID          2
`define SMW_IN_ALM          3
`define SMW_IN_E0           4
`define SMW_IN_E1           5
`define SMW_IN_RX           6
`define SMW_IN_RST          7
`endif

// ==== smw_pkg.sv ====
// types shared by the sleep wake-up control block
`default_nettype none
package smw_pkg;
  typedef enum logic [1:0] {
    SMW_NORMAL,
    SMW_BATTERY,
    SMW_SLEEP
  } smw_mode_t;
endpackage : smw_pkg
`default_nettype wire

// ==== smw_pin_sync.sv ====
// two-flop synchronisers with edge detection for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module smw_pin_sync #(
  parameter int        N       = 8,
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] pin_in,
  output logic      [N-1:0] level,
  output logic      [N-1:0] rise,
  output logic      [N-1:0] fall
);
  logic [N-1:0] meta_ff;
  logic [N-1:0] sync_ff;
  logic [N-1:0] prev_ff;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_ff[i] <= RST_VAL[i];
          sync_ff[i] <= RST_VAL[i];
          prev_ff[i] <= RST_VAL[i];
        end else begin
          meta_ff[i] <= pin_in[i];
          sync_ff[i] <= meta_ff[i];
          prev_ff[i] <= sync_ff[i];
        end
      end
      // edges only from the second stage onward
      assign level[i] = sync_ff[i];
      assign rise[i]  = sync_ff[i] & ~prev_ff[i];
      assign fall[i]  = ~sync_ff[i] & prev_ff[i];
    end
  endgenerate
endmodule : smw_pin_sync
`default_nettype wire

// ==== smw_wake_ctrl.sv ====
// deepest-sleep wake-up source control with its register file
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "smw_defs.svh"
module smw_wake_ctrl
  import smw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        dc_input_change,
  input  wire logic        switched_supply_rail,
  input  wire logic        rtc_midnight,
  input  wire logic        rtc_alarm,
  input  wire logic        ext_irq0_n,
  input  wire logic        ext_irq1_n,
  input  wire logic        serial_rx,
  input  wire logic        reset_pin_n,
  input  wire logic [23:0] gpio_oe_req,
  output logic      [23:0] gpio_oe,
  output logic      [23:0] pullup_en,
  output logic             display_enable,
  output logic             core_shutdown,
  output logic             core_restart,
  output logic             power_mgmt_vector,
  output logic             calendar_irq_vector,
  output var smw_mode_t    power_mode
);
  logic [7:0] pin_lvl;
  logic [7:0] pin_rise;
  logic [7:0] pin_fall;

  smw_pin_sync #(
    .N       (8),
    .RST_VAL (`SMW_SYNC_RST)
  ) u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .pin_in ({reset_pin_n, serial_rx, ext_irq1_n, ext_irq0_n,
              rtc_alarm, rtc_midnight, switched_supply_rail,
              dc_input_change}),
    .level  (pin_lvl),
    .rise   (pin_rise),
    .fall   (pin_fall)
  );

  logic       asleep_ff;
  logic [7:0] clock_config_ff;
  logic [7:0] pu0_ff;
  logic [7:0] pu1_ff;
  logic [7:0] pu2_ff;
  logic [7:0] pmie_ff;
  logic [1:0] rx_sel_ff;
  logic       rx_flag_ff;
  logic [3:0] pinsel_ff;
  logic       e0_edge_ff;
  logic       e1_edge_ff;
  logic       e0_latch_ff;
  logic       e1_latch_ff;
  logic       dc_flag_ff;
  logic       sup_flag_ff;
  logic       mid_flag_ff;
  logic       alm_flag_ff;
  logic       disp_en_ff;
  logic [7:0] scratch_ff [4];
  logic [7:0] rdata_ff;
  logic [23:0] gpio_oe_ff;
  logic       restart_ff;
  logic       pm_vec_ff;
  logic       cal_vec_ff;
  smw_mode_t  mode_ff;
  smw_mode_t  nxt_mode;

  logic rail_main;
  logic e0_ev;
  logic e1_ev;
  logic rx_ev;
  logic wake_any;
  logic wake_req;
  logic wr_stat;
  logic wr_tirq;
  logic wr_per;
  logic sleep_cmd;

  assign rail_main = pin_lvl[`SMW_IN_RAIL];
  assign wr_stat   = reg_wr && (reg_addr == `SMW_WSTAT_ADDR);
  assign wr_tirq   = reg_wr && (reg_addr == `SMW_TIRQ_ADDR);
  assign wr_per    = reg_wr && (reg_addr == `SMW_PCFG_ADDR);
  // sleep only makes sense on battery; on main the request is ignored
  assign sleep_cmd = reg_wr && (reg_addr == `SMW_PWRCTL_ADDR)
                     && reg_wdata[`SMW_SLEEP_BIT] && !rail_main;

  // pins are active low; edge select 1 picks the falling edge
  assign e0_ev = e0_edge_ff ? pin_fall[`SMW_IN_E0]
                            : pin_rise[`SMW_IN_E0];
  assign e1_ev = e1_edge_ff ? pin_fall[`SMW_IN_E1]
                            : pin_rise[`SMW_IN_E1];
  assign rx_ev = (rx_sel_ff == 2'h3) &&
                 (pin_rise[`SMW_IN_RX] || pin_fall[`SMW_IN_RX]);

  always_comb begin
    wake_any = 1'b0;
    if (dc_flag_ff && pmie_ff[`SMW_DC_EN_BIT]) wake_any = 1'b1;
    if (pin_rise[`SMW_IN_RAIL]) wake_any = 1'b1;
    if (mid_flag_ff) wake_any = 1'b1;
    if (alm_flag_ff && clock_config_ff[`SMW_ALARM_EN_BIT]) begin
      wake_any = 1'b1;
    end
    if (pinsel_ff[0] && e0_ev) wake_any = 1'b1;
    if ((pinsel_ff[3:2] == 2'h3) && e1_ev) wake_any = 1'b1;
    if (rx_ev) wake_any = 1'b1;
    if (!pin_lvl[`SMW_IN_RST]) wake_any = 1'b1;
  end

  // all sources already passed the synchronisers
  assign wake_req = asleep_ff && wake_any;

  // sleep state doubles as the core shutdown output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      asleep_ff <= 1'b0;
    end else if (wake_req) begin
      asleep_ff <= 1'b0;
    end else if (sleep_cmd) begin
      asleep_ff <= 1'b1;
    end
  end

  // event flags: a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dc_flag_ff  <= 1'b0;
      sup_flag_ff <= 1'b0;
      mid_flag_ff <= 1'b0;
      alm_flag_ff <= 1'b0;
      rx_flag_ff  <= 1'b0;
      e0_latch_ff <= 1'b0;
      e1_latch_ff <= 1'b0;
    end else begin
      dc_flag_ff  <= pin_rise[`SMW_IN_DC] ||
                     (dc_flag_ff && !(wr_stat && reg_wdata[`SMW_ST_DC_BIT]));
      sup_flag_ff <= pin_rise[`SMW_IN_RAIL] ||
                     (sup_flag_ff && !(wr_stat && reg_wdata[`SMW_ST_SUP_BIT]));
      mid_flag_ff <= pin_rise[`SMW_IN_MID] ||
                     (mid_flag_ff && !(wr_stat && reg_wdata[`SMW_ST_MID_BIT]));
      alm_flag_ff <= pin_rise[`SMW_IN_ALM] ||
                     (alm_flag_ff && !(wr_stat && reg_wdata[`SMW_ST_ALM_BIT]));
      rx_flag_ff  <= rx_ev ||
                     (rx_flag_ff && !(wr_per && reg_wdata[`SMW_RXFLAG_BIT]));
      // a wake edge during sleep leaves the latches alone
      e0_latch_ff <= (!asleep_ff && e0_ev) ||
        (e0_latch_ff && !(wr_tirq && reg_wdata[`SMW_E0_LATCH_BIT]));
      e1_latch_ff <= (!asleep_ff && e1_ev) ||
        (e1_latch_ff && !(wr_tirq && reg_wdata[`SMW_E1_LATCH_BIT]));
    end
  end

  // configuration kept across sleep; only rst_n clears it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_config_ff <= `SMW_REG_RST;
      pu0_ff          <= `SMW_PU_RST;
      pu1_ff          <= `SMW_PU_RST;
      pu2_ff          <= `SMW_PU_RST;
      pmie_ff         <= `SMW_REG_RST;
      rx_sel_ff       <= 2'h0;
      pinsel_ff       <= 4'h0;
      e0_edge_ff      <= 1'b0;
      e1_edge_ff      <= 1'b0;
      disp_en_ff      <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        `SMW_CLKCFG_ADDR: clock_config_ff <= reg_wdata;
        `SMW_PU0_ADDR:    pu0_ff <= reg_wdata;
        `SMW_PU1_ADDR:    pu1_ff <= reg_wdata;
        `SMW_PU2_ADDR:    pu2_ff <= reg_wdata;
        `SMW_PMIE_ADDR:   pmie_ff <= reg_wdata;
        `SMW_PCFG_ADDR:   rx_sel_ff <= reg_wdata[1:0];
        `SMW_PINSEL_ADDR: pinsel_ff <= reg_wdata[3:0];
        `SMW_TIRQ_ADDR: begin
          e0_edge_ff <= reg_wdata[`SMW_E0_EDGE_BIT];
          e1_edge_ff <= reg_wdata[`SMW_E1_EDGE_BIT];
        end
        `SMW_PWRCTL_ADDR: disp_en_ff <= reg_wdata[`SMW_DISP_EN_BIT];
        default: ;
      endcase
    end
  end

  // scratch words survive sleep; no wake path touches them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < 4; k++) scratch_ff[k] <= `SMW_REG_RST;
    end else if (reg_wr && reg_addr >= `SMW_SCR0_ADDR &&
                 reg_addr <= `SMW_SCR3_ADDR) begin
      scratch_ff[2'(reg_addr - `SMW_SCR0_ADDR)] <= reg_wdata;
    end
  end

  always_comb begin
    case (mode_ff)
      SMW_NORMAL:  nxt_mode = rail_main ? SMW_NORMAL : SMW_BATTERY;
      SMW_BATTERY: nxt_mode = rail_main ? SMW_NORMAL :
                              (asleep_ff ? SMW_SLEEP : SMW_BATTERY);
      SMW_SLEEP:   nxt_mode = rail_main ? SMW_NORMAL :
                              (asleep_ff ? SMW_SLEEP : SMW_BATTERY);
      default:     nxt_mode = SMW_BATTERY;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff    <= SMW_BATTERY;
      gpio_oe_ff <= 24'h000000;
      restart_ff <= 1'b0;
      pm_vec_ff  <= 1'b0;
      cal_vec_ff <= 1'b0;
    end else begin
      mode_ff    <= nxt_mode;
      gpio_oe_ff <= asleep_ff ? 24'h000000 : gpio_oe_req;
      restart_ff <= wake_req;
      pm_vec_ff  <= (dc_flag_ff && pmie_ff[`SMW_DC_EN_BIT]) ||
                    sup_flag_ff;
      cal_vec_ff <= mid_flag_ff ||
                    (alm_flag_ff && clock_config_ff[`SMW_ALARM_EN_BIT]);
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (!reg_rd) begin
      rdata_ff <= 8'h00;
    end else begin
      case (reg_addr)
        `SMW_CLKCFG_ADDR: rdata_ff <= clock_config_ff;
        `SMW_PU0_ADDR:    rdata_ff <= pu0_ff;
        `SMW_PU1_ADDR:    rdata_ff <= pu1_ff;
        `SMW_PU2_ADDR:    rdata_ff <= pu2_ff;
        `SMW_PMIE_ADDR:   rdata_ff <= pmie_ff;
        `SMW_PCFG_ADDR:   rdata_ff <= {rx_flag_ff, rail_main,
                                       4'h0, rx_sel_ff};
        `SMW_PINSEL_ADDR: rdata_ff <= {4'h0, pinsel_ff};
        `SMW_TIRQ_ADDR:   rdata_ff <= {4'h0, e1_latch_ff, e0_latch_ff,
                                       e1_edge_ff, e0_edge_ff};
        `SMW_WSTAT_ADDR:  rdata_ff <= {4'h0, alm_flag_ff, mid_flag_ff,
                                       sup_flag_ff, dc_flag_ff};
        `SMW_PWRCTL_ADDR: rdata_ff <= {3'h0, asleep_ff, 3'h0, disp_en_ff};
        `SMW_SCR0_ADDR, 8'hfc, 8'hfd, `SMW_SCR3_ADDR:
          rdata_ff <= scratch_ff[2'(reg_addr - `SMW_SCR0_ADDR)];
        default:          rdata_ff <= 8'h00;
      endcase
    end
  end

  assign reg_rdata           = rdata_ff;
  assign gpio_oe             = gpio_oe_ff;
  assign pullup_en           = {pu2_ff, pu1_ff, pu0_ff};
  assign display_enable      = disp_en_ff;
  assign core_shutdown       = asleep_ff;
  assign core_restart        = restart_ff;
  assign power_mgmt_vector   = pm_vec_ff;
  assign calendar_irq_vector = cal_vec_ff;
  assign power_mode          = mode_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_exit;
    $fell(asleep_ff);
  endsequence
  sequence s_restart_pulse;
    core_restart ##1 !core_restart;
  endsequence

  a_dc_wake_gate: assert property (asleep_ff && dc_flag_ff &&
    pmie_ff[`SMW_DC_EN_BIT] |=> !asleep_ff ##1 power_mgmt_vector)
    else $error("dc change did not wake");
  a_supply_wake: assert property (asleep_ff &&
    pin_rise[`SMW_IN_RAIL] |=> !asleep_ff ##1 power_mgmt_vector)
    else $error("supply restore did not wake");
  a_src_status: assert property (reg_rd &&
    reg_addr == `SMW_PCFG_ADDR |=> reg_rdata[6] == $past(rail_main))
    else $error("supply source bit wrong");
  a_midnight_wake: assert property (asleep_ff && mid_flag_ff
    |=> !asleep_ff ##1 calendar_irq_vector)
    else $error("midnight did not wake");
  a_alarm_masked: assert property (asleep_ff && alm_flag_ff &&
    !clock_config_ff[`SMW_ALARM_EN_BIT] && !wake_req |=> asleep_ff)
    else $error("masked alarm woke core");
  a_gpio_input: assert property (asleep_ff |=> gpio_oe == 24'h000000)
    else $error("gpio driven in sleep");
  a_latch_kept: assert property (asleep_ff && !e0_latch_ff &&
    !e1_latch_ff |=> !e0_latch_ff && !e1_latch_ff)
    else $error("irq latch set by wake");
  a_rx_edge_wake: assert property (asleep_ff && rx_ev
    |=> rx_flag_ff && !asleep_ff)
    else $error("rx edge did not wake");
  a_reset_wake: assert property (asleep_ff &&
    !pin_lvl[`SMW_IN_RST] && !rail_main |=> !asleep_ff ##1
    power_mode == SMW_BATTERY)
    else $error("reset pin did not wake");
  a_restart_exit: assert property (s_exit |-> s_restart_pulse)
    else $error("no restart on exit");
  a_mode_main: assert property (rail_main |=> power_mode == SMW_NORMAL)
    else $error("mode ignores main rail");
endmodule : smw_wake_ctrl
`default_nettype wire

// ==== smw_wake_ctrl_bench.sv ====
// self-checking bench for the sleep wake-up control block
`timescale 1ns/1ps
`default_nettype none
module smw_wake_ctrl_bench
  import smw_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        dc_input_change;
  logic        switched_supply_rail;
  logic        rtc_midnight;
  logic        rtc_alarm;
  logic        ext_irq0_n;
  logic        ext_irq1_n;
  logic        serial_rx;
  logic        reset_pin_n;
  logic [23:0] gpio_oe_req;
  logic [23:0] gpio_oe;
  logic [23:0] pullup_en;
  logic        display_enable;
  logic        core_shutdown;
  logic        core_restart;
  logic        power_mgmt_vector;
  logic        calendar_irq_vector;
  smw_mode_t   power_mode;
  int          n_errors;
  int          compares;

  smw_wake_ctrl smw_wake_ctrl_i (
    .clk                 (clk),
    .rst_n               (rst_n),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .dc_input_change     (dc_input_change),
    .switched_supply_rail(switched_supply_rail),
    .rtc_midnight        (rtc_midnight),
    .rtc_alarm           (rtc_alarm),
    .ext_irq0_n          (ext_irq0_n),
    .ext_irq1_n          (ext_irq1_n),
    .serial_rx           (serial_rx),
    .reset_pin_n         (reset_pin_n),
    .gpio_oe_req         (gpio_oe_req),
    .gpio_oe             (gpio_oe),
    .pullup_en           (pullup_en),
    .display_enable      (display_enable),
    .core_shutdown       (core_shutdown),
    .core_restart        (core_restart),
    .power_mgmt_vector   (power_mgmt_vector),
    .calendar_irq_vector (calendar_irq_vector),
    .power_mode          (power_mode)
  );

  always #2 clk = ~clk;

  task automatic stop_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    compares++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                     input string nm);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(nm, {16'h0, e}, {16'h0, reg_rdata});
  endtask : rdc

  task automatic go_sleep(input logic [7:0] v);
    wr(8'hc5, v);
    @(posedge clk);
    #1 chk("shutdown", 24'h1, {23'h0, core_shutdown});
  endtask : go_sleep

  // pins pass three flops, so twenty cycles is ample
  task automatic wait_wake(input string nm);
    int   i;
    logic seen;
    seen = 1'b0;
    for (i = 0; i < 20 && !seen; i++) begin
      @(posedge clk);
      #1 seen = (core_restart === 1'b1);
    end
    chk(nm, 24'h1, {23'h0, seen});
    chk("awake", 24'h0, {23'h0, core_shutdown});
    if (!seen) stop_test();
  endtask : wait_wake

  task automatic hold_sleep(input string nm);
    repeat (10) @(posedge clk);
    #1 chk(nm, 24'h1, {23'h0, core_shutdown});
  endtask : hold_sleep

  initial begin
    int k;
    clk = 1'b0;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    dc_input_change = 1'b0;
    switched_supply_rail = 1'b0;
    rtc_midnight = 1'b0;
    rtc_alarm = 1'b0;
    ext_irq0_n = 1'b1;
    ext_irq1_n = 1'b1;
    serial_rx = 1'b1;
    reset_pin_n = 1'b1;
    gpio_oe_req = 24'habcdef;
    n_errors = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("pullup_rst", 24'hffffff, pullup_en);
    chk("mode_rst", {22'h0, SMW_BATTERY}, {22'h0, power_mode});
    for (k = 0; k < 4; k++) wr(8'(8'hfb + k), 8'(8'h3c ^ k));
    wr(8'hb2, 8'h5a);
    wr(8'hb3, 8'h0f);
    wr(8'hb4, 8'h81);
    wr(8'h80, 8'hff);
    rdc(8'h80, 8'h00, "unmapped");
    rdc(8'hf4, 8'h00, "pcfg_bat");
    chk("gpio_awake", 24'habcdef, gpio_oe);
    go_sleep(8'h11);
    chk("gpio_sleep", 24'h0, gpio_oe);
    chk("pullup_sleep", 24'h810f5a, pullup_en);
    chk("display_on", 24'h1, {23'h0, display_enable});
    chk("mode_sleep", {22'h0, SMW_SLEEP}, {22'h0, power_mode});
    // masked dc change must hold; enabling it then wakes at once
    @(posedge clk);
    dc_input_change <= 1'b1;
    hold_sleep("dc_masked");
    wr(8'hec, 8'h01);
    wait_wake("dc_wake");
    chk("pm_vec_dc", 24'h1, {23'h0, power_mgmt_vector});
    @(posedge clk);
    dc_input_change <= 1'b0;
    wr(8'hda, 8'h01);
    go_sleep(8'h10);
    chk("display_off", 24'h0, {23'h0, display_enable});
    @(posedge clk);
    rtc_midnight <= 1'b1;
    wait_wake("midnight");
    chk("cal_vec", 24'h1, {23'h0, calendar_irq_vector});
    @(posedge clk);
    rtc_midnight <= 1'b0;
    wr(8'hda, 8'h04);
    go_sleep(8'h10);
    @(posedge clk);
    rtc_alarm <= 1'b1;
    hold_sleep("alarm_masked");
    wr(8'ha1, 8'h02);
    wait_wake("alarm");
    @(posedge clk);
    rtc_alarm <= 1'b0;
    wr(8'hda, 8'h08);
    // irq0 on falling edge, irq1 on rising edge with select 11
    wr(8'hdb, 8'h0d);
    wr(8'hd9, 8'h01);
    go_sleep(8'h10);
    @(posedge clk);
    ext_irq0_n <= 1'b0;
    wait_wake("irq0");
    rdc(8'hd9, 8'h01, "latch0");
    @(posedge clk);
    ext_irq0_n <= 1'b1;
    ext_irq1_n <= 1'b0;
    go_sleep(8'h10);
    @(posedge clk);
    ext_irq1_n <= 1'b1;
    wait_wake("irq1");
    rdc(8'hd9, 8'h01, "latch1");
    // an awake edge must latch, and software acknowledges it
    @(posedge clk);
    ext_irq0_n <= 1'b0;
    repeat (4) @(posedge clk);
    rdc(8'hd9, 8'h05, "latch_awake");
    wr(8'hd9, 8'h05);
    rdc(8'hd9, 8'h01, "latch_clear");
    wr(8'hf4, 8'h03);
    for (k = 0; k < 2; k++) begin
      go_sleep(8'h10);
      @(posedge clk);
      serial_rx <= k[0];
      wait_wake("rx_edge");
      rdc(8'hf4, 8'h83, "rx_flag");
      wr(8'hf4, 8'h83);
    end
    rdc(8'hf4, 8'h03, "rx_clear");
    go_sleep(8'h10);
    @(posedge clk);
    reset_pin_n <= 1'b0;
    wait_wake("reset_pin");
    @(posedge clk);
    #1 chk("mode_rpin", {22'h0, SMW_BATTERY}, {22'h0, power_mode});
    @(posedge clk);
    reset_pin_n <= 1'b1;
    repeat (4) @(posedge clk);
    go_sleep(8'h10);
    @(posedge clk);
    switched_supply_rail <= 1'b1;
    wait_wake("rail");
    // the vector follows the restored flag one cycle after the wake
    @(posedge clk);
    #1 chk("pm_vec_sup", 24'h1, {23'h0, power_mgmt_vector});
    chk("mode_main", {22'h0, SMW_NORMAL}, {22'h0, power_mode});
    rdc(8'hf4, 8'h43, "supply_src");
    // sleep is refused while the rail sits on the main supply
    wr(8'hc5, 8'h10);
    @(posedge clk);
    #1 chk("no_sleep_main", 24'h0, {23'h0, core_shutdown});
    for (k = 0; k < 4; k++) rdc(8'(8'hfb + k), 8'(8'h3c ^ k), "scr");
    stop_test();
  end
endmodule : smw_wake_ctrl_bench
`default_nettype wire
